//--- common/iiaem_pkg.sv
// constants and types for the ipv6 icmp access-control entry matcher
package iiaem_pkg;

  // ==========================================================
  // bus
  // ==========================================================
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;

  // ==========================================================
  // register map (byte offsets)
  // ==========================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_NH_VALUE = 8'h04;
  localparam logic [7:0] OFS_SRC_ADDR = 8'h08;
  localparam logic [7:0] OFS_SRC_MASK = 8'h0c;
  localparam logic [7:0] OFS_ICMP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int OFS_W = 8;

  // ==========================================================
  // control fields
  // ==========================================================
  localparam int CTRL_NH_LSB = 0;
  localparam int CTRL_NH_W = 3;
  localparam int CTRL_SRC_BIT = 3;
  localparam int CTRL_HOP_LSB = 4;
  localparam int CTRL_HOP_W = 2;
  localparam int CTRL_TYPE_BIT = 6;
  localparam int CTRL_CODE_BIT = 7;
  localparam int CTRL_W = 8;
  localparam int ICMP_TYPE_LSB = 0;
  localparam int ICMP_CODE_LSB = 8;
  localparam int STAT_HIT_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_CNT_LSB = 16;
  localparam int CNT_W = 16;

  // ==========================================================
  // reset values and protocol numbers
  // ==========================================================
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [31:0] SRC_MASK_RST = 32'hffffffff;
  localparam logic [7:0] PROTO_ICMP6 = 8'h3a;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam logic [7:0] PROTO_TCP = 8'h06;

  // ==========================================================
  // criterion selections
  // ==========================================================
  typedef enum logic [CTRL_NH_W-1:0] {NH_ANY, NH_SPECIFIC, NH_ICMP, NH_UDP, NH_TCP} iiaem_nh_mode_t;
  typedef enum logic [CTRL_HOP_W-1:0] {HOP_ANY, HOP_ZERO, HOP_NONZERO} iiaem_hop_mode_t;

  typedef struct packed {
    logic valid;
    logic is_ipv6;
    logic [7:0] next_hdr;
    logic [31:0] src_low;
    logic [7:0] hop_limit;
    logic [7:0] icmp_type;
    logic [7:0] icmp_code;
  } iiaem_frame_t;

  typedef struct packed {
    logic valid;
    logic hit;
  } iiaem_result_t;

endpackage : iiaem_pkg

//--- hw/iiaem_matcher.sv
// access-control entry match logic for ipv6 frames, with ahb-lite configuration
`timescale 1ns/1ps

// Function
// RULE_01: with the next-header selection at don't-care any next-header value is accepted.
// RULE_02: with a specific next-header selection only the configured 8-bit value matches.
// RULE_03: icmp, udp and tcp selections restrict the entry to ipv6 frames of that protocol.
// RULE_04: with the source-address selection at don't-care any source address is accepted.
// RULE_05: a specific source selection compares only the low 32 source-address bits.
// RULE_06: a mask bit at 0 makes that source-address bit don't-care.
// RULE_07: the comparison is configured address and mask against frame low bits and mask.
// RULE_08: with hop-limit at zero, frames with a hop limit above zero never hit.
// RULE_09: with hop-limit at non-zero, frames with a hop limit above zero stay eligible.
// RULE_10: with hop-limit at don't-care any hop limit is accepted.
// RULE_11: with the icmp type at don't-care any icmp type is accepted.
// RULE_12: with a specific icmp type only the configured 8-bit type matches.
// RULE_13: with the icmp code at don't-care any icmp code is accepted.
// RULE_14: with a specific icmp code only the configured 8-bit code matches.
// RULE_15: a hit needs every enabled criterion to match, don't-care criteria always match.
// RULE_16: icmp type and code are looked at only under the icmp next-header selection.
module iiaem_matcher (
  input wire logic MCLK_IN,
  input wire logic RST_B_IN,
  input wire logic HSEL_IN,
  input wire logic [iiaem_pkg::ADDR_W-1:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [iiaem_pkg::DATA_W-1:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [iiaem_pkg::DATA_W-1:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire iiaem_pkg::iiaem_frame_t FRAME_IN,
  output iiaem_pkg::iiaem_result_t RESULT_OUT
);
  import iiaem_pkg::*;

  // ==========================================================
  // configuration and status state
  // ==========================================================
  logic [CTRL_W-1:0] ctrl_reg;
  logic [7:0] nh_value_reg;
  logic [31:0] src_addr_reg;
  logic [31:0] src_mask_reg;
  logic [7:0] icmp_type_reg;
  logic [7:0] icmp_code_reg;
  logic [CNT_W-1:0] hit_cnt_reg;
  logic [CNT_W-1:0] hit_cnt_next;
  logic result_valid_reg;
  logic result_hit_reg;

  // ==========================================================
  // bus pipeline state
  // ==========================================================
  logic wr_pend_reg;
  logic [OFS_W-1:0] wr_ofs_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic addr_phase;
  logic [OFS_W-1:0] ofs_in;
  logic cnt_clear;

  // ==========================================================
  // match terms
  // ==========================================================
  iiaem_nh_mode_t nh_mode;
  iiaem_hop_mode_t hop_mode;
  logic src_specific;
  logic type_specific;
  logic code_specific;
  logic nh_ok;
  logic src_ok;
  logic hop_ok;
  logic type_ok;
  logic code_ok;
  logic icmp_ok;
  logic entry_hit;
  logic [31:0] cfg_masked;
  logic [31:0] frm_masked;

  assign nh_mode = iiaem_nh_mode_t'(ctrl_reg[CTRL_NH_LSB +: CTRL_NH_W]);
  assign hop_mode = iiaem_hop_mode_t'(ctrl_reg[CTRL_HOP_LSB +: CTRL_HOP_W]);
  assign src_specific = ctrl_reg[CTRL_SRC_BIT];
  assign type_specific = ctrl_reg[CTRL_TYPE_BIT];
  assign code_specific = ctrl_reg[CTRL_CODE_BIT];

  // ==========================================================
  // next-header criterion
  // ==========================================================
  // unused selection codes never match, so a bad write cannot open the entry
  always_comb begin
    case (nh_mode)
      NH_ANY: begin
        nh_ok = 1'b1; // RULE_01
      end
      NH_SPECIFIC: begin
        nh_ok = (FRAME_IN.next_hdr == nh_value_reg); // RULE_02
      end
      NH_ICMP: begin
        nh_ok = (FRAME_IN.next_hdr == PROTO_ICMP6); // RULE_03
      end
      NH_UDP: begin
        nh_ok = (FRAME_IN.next_hdr == PROTO_UDP); // RULE_03
      end
      NH_TCP: begin
        nh_ok = (FRAME_IN.next_hdr == PROTO_TCP); // RULE_03
      end
      default: begin
        nh_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // source-address criterion
  // ==========================================================
  // only the low 32 address bits reach this block at all
  assign cfg_masked = src_addr_reg & src_mask_reg; // RULE_07
  assign frm_masked = FRAME_IN.src_low & src_mask_reg; // RULE_06
  assign src_ok = !src_specific || (cfg_masked == frm_masked); // RULE_04 RULE_05

  // ==========================================================
  // hop-limit criterion
  // ==========================================================
  always_comb begin
    case (hop_mode)
      HOP_ANY: begin
        hop_ok = 1'b1; // RULE_10
      end
      HOP_ZERO: begin
        hop_ok = (FRAME_IN.hop_limit == 8'h00); // RULE_08
      end
      HOP_NONZERO: begin
        hop_ok = (FRAME_IN.hop_limit != 8'h00); // RULE_09
      end
      default: begin
        hop_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // icmp criteria
  // ==========================================================
  assign type_ok = !type_specific || (FRAME_IN.icmp_type == icmp_type_reg); // RULE_11 RULE_12
  assign code_ok = !code_specific || (FRAME_IN.icmp_code == icmp_code_reg); // RULE_13 RULE_14
  assign icmp_ok = (nh_mode != NH_ICMP) || (type_ok && code_ok); // RULE_16

  // non-ipv6 frames are outside this entry's reach whatever the selections
  assign entry_hit = FRAME_IN.is_ipv6 && nh_ok && src_ok && hop_ok && icmp_ok; // RULE_15 RULE_03

  // ==========================================================
  // result pipeline
  // ==========================================================
  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      result_valid_reg <= 1'b0;
      result_hit_reg <= 1'b0;
    end else begin
      result_valid_reg <= FRAME_IN.valid;
      result_hit_reg <= FRAME_IN.valid && entry_hit; // RULE_15
    end
  end

  assign RESULT_OUT.valid = result_valid_reg;
  assign RESULT_OUT.hit = result_hit_reg;

  // hit counter saturates; a hit in the clearing cycle is still counted
  always_comb begin
    hit_cnt_next = hit_cnt_reg;
    if (cnt_clear) begin
      hit_cnt_next = '0;
    end
    if (result_hit_reg && (hit_cnt_next != {CNT_W{1'b1}})) begin
      hit_cnt_next = hit_cnt_next + 1'b1;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      hit_cnt_reg <= '0;
    end else begin
      hit_cnt_reg <= hit_cnt_next;
    end
  end

  // ==========================================================
  // ahb-lite slave: address phase
  // ==========================================================
  assign addr_phase = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  assign ofs_in = HADDR_IN[OFS_W-1:0];

  // read data is taken at the address edge, zero wait states; a read
  // directly behind a write to the same register sees the old value
  always_comb begin
    rdata_next = '0;
    case (ofs_in)
      OFS_CTRL: begin
        rdata_next[CTRL_W-1:0] = ctrl_reg;
      end
      OFS_NH_VALUE: begin
        rdata_next[7:0] = nh_value_reg;
      end
      OFS_SRC_ADDR: begin
        rdata_next = src_addr_reg;
      end
      OFS_SRC_MASK: begin
        rdata_next = src_mask_reg;
      end
      OFS_ICMP: begin
        rdata_next[ICMP_TYPE_LSB +: 8] = icmp_type_reg;
        rdata_next[ICMP_CODE_LSB +: 8] = icmp_code_reg;
      end
      OFS_STATUS: begin
        rdata_next[STAT_HIT_BIT] = result_hit_reg;
        rdata_next[STAT_VALID_BIT] = result_valid_reg;
        rdata_next[STAT_CNT_LSB +: CNT_W] = hit_cnt_reg;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      rdata_reg <= '0;
    end else if (addr_phase && !HWRITE_IN) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= '0;
    end else if (HREADY_IN) begin
      wr_pend_reg <= addr_phase && HWRITE_IN;
      wr_ofs_reg <= ofs_in;
    end
  end

  assign HRDATA_OUT = rdata_reg;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = HRESP_OKAY;

  // ==========================================================
  // ahb-lite slave: data phase writes
  // ==========================================================
  // unmapped offsets and hsize are not checked: writes land as whole words
  assign cnt_clear = wr_pend_reg && (wr_ofs_reg == OFS_STATUS);

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_pend_reg && (wr_ofs_reg == OFS_CTRL)) begin
      ctrl_reg <= HWDATA_IN[CTRL_W-1:0];
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      nh_value_reg <= '0;
    end else if (wr_pend_reg && (wr_ofs_reg == OFS_NH_VALUE)) begin
      nh_value_reg <= HWDATA_IN[7:0];
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      src_addr_reg <= '0;
      src_mask_reg <= SRC_MASK_RST;
    end else if (wr_pend_reg && (wr_ofs_reg == OFS_SRC_ADDR)) begin
      src_addr_reg <= HWDATA_IN;
    end else if (wr_pend_reg && (wr_ofs_reg == OFS_SRC_MASK)) begin
      src_mask_reg <= HWDATA_IN;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      icmp_type_reg <= '0;
      icmp_code_reg <= '0;
    end else if (wr_pend_reg && (wr_ofs_reg == OFS_ICMP)) begin
      icmp_type_reg <= HWDATA_IN[ICMP_TYPE_LSB +: 8];
      icmp_code_reg <= HWDATA_IN[ICMP_CODE_LSB +: 8];
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  chk_nh_any_open: assert property ( // RULE_01
    FRAME_IN.valid && FRAME_IN.is_ipv6 && (nh_mode == NH_ANY) && src_ok && hop_ok
      |=> result_hit_reg)
    else $error("next-header any blocked a frame");

  chk_nh_value_eq: assert property ( // RULE_02
    FRAME_IN.valid && (nh_mode == NH_SPECIFIC) && (FRAME_IN.next_hdr != nh_value_reg)
      |=> !result_hit_reg)
    else $error("specific next-header hit on other value");

  chk_proto_short: assert property ( // RULE_03
    FRAME_IN.valid && ((nh_mode == NH_UDP && FRAME_IN.next_hdr != PROTO_UDP)
      || (nh_mode == NH_TCP && FRAME_IN.next_hdr != PROTO_TCP) || !FRAME_IN.is_ipv6)
      |=> !result_hit_reg)
    else $error("protocol shortcut hit on wrong frame");

  chk_src_any: assert property ( // RULE_04
    !src_specific |-> src_ok)
    else $error("source any rejected an address");

  chk_src_masked: assert property ( // RULE_05
    src_specific |-> (src_ok == (((src_addr_reg ^ FRAME_IN.src_low) & src_mask_reg) == 32'h00000000)))
    else $error("masked source compare wrong");

  chk_mask_zero: assert property ( // RULE_06
    src_specific && (src_mask_reg == 32'h00000000) |-> src_ok)
    else $error("zero mask still compared bits");

  chk_src_miss: assert property ( // RULE_07
    FRAME_IN.valid && src_specific && (((src_addr_reg ^ FRAME_IN.src_low) & src_mask_reg) != 32'h00000000)
      |=> !result_hit_reg)
    else $error("source mismatch still hit");

  chk_hop_zero: assert property ( // RULE_08
    FRAME_IN.valid && (hop_mode == HOP_ZERO) && (FRAME_IN.hop_limit != 8'h00)
      |=> !result_hit_reg && result_valid_reg)
    else $error("hop zero hit a live frame");

  chk_hop_nonzero: assert property ( // RULE_09
    (hop_mode == HOP_NONZERO) |-> (hop_ok == (FRAME_IN.hop_limit != 8'h00)))
    else $error("hop non-zero wrong");

  chk_hop_any: assert property ( // RULE_10
    (hop_mode == HOP_ANY) |-> hop_ok)
    else $error("hop any rejected a frame");

  chk_type_any: assert property ( // RULE_11
    !type_specific |-> type_ok)
    else $error("icmp type any rejected");

  chk_type_value: assert property ( // RULE_12
    FRAME_IN.valid && (nh_mode == NH_ICMP) && type_specific && (FRAME_IN.icmp_type != icmp_type_reg)
      |=> !result_hit_reg)
    else $error("icmp type mismatch hit");

  chk_code_any: assert property ( // RULE_13
    !code_specific |-> code_ok)
    else $error("icmp code any rejected");

  chk_code_value: assert property ( // RULE_14
    FRAME_IN.valid && (nh_mode == NH_ICMP) && code_specific && (FRAME_IN.icmp_code != icmp_code_reg)
      |=> !result_hit_reg)
    else $error("icmp code mismatch hit");

  chk_hit_all: assert property ( // RULE_15
    result_hit_reg |-> $past(FRAME_IN.valid && FRAME_IN.is_ipv6 && nh_ok && src_ok && hop_ok && icmp_ok))
    else $error("hit without every criterion");

  chk_icmp_ignored: assert property ( // RULE_16
    FRAME_IN.valid && FRAME_IN.is_ipv6 && (nh_mode == NH_UDP) && (FRAME_IN.next_hdr == PROTO_UDP)
      && (type_specific || code_specific) && src_ok && hop_ok |=> result_hit_reg)
    else $error("icmp criteria used outside icmp");

  cov_icmp_hit: cover property (
    FRAME_IN.valid && (nh_mode == NH_ICMP) && type_specific && code_specific ##1 result_hit_reg);
  cov_src_hit: cover property (
    FRAME_IN.valid && src_specific && (src_mask_reg != SRC_MASK_RST) ##1 result_hit_reg);
  cov_hop_block: cover property (
    FRAME_IN.valid && (hop_mode == HOP_ZERO) ##1 result_valid_reg && !result_hit_reg);
  cov_cnt_clear: cover property (
    cnt_clear && result_hit_reg);

endmodule : iiaem_matcher

//--- verif/iiaem_matcher_tb.sv
// self-checking bench for the ipv6 icmp access-control entry matcher
`timescale 1ns/1ps

module iiaem_matcher_tb;
  import iiaem_pkg::*;

  // ==========================================================
  // signals
  // ==========================================================
  logic mclk;
  logic rst_b;
  logic hsel;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [DATA_W-1:0] hwdata;
  logic [DATA_W-1:0] hrdata;
  logic hreadyout;
  logic hresp;
  iiaem_frame_t frame;
  iiaem_result_t result;
  int n_fail;
  int checks;
  logic [31:0] rd;
  logic [7:0] ofs_tab [7];
  logic [31:0] rst_tab [7];
  logic [7:0] pr [3];
  logic [7:0] nv [2];

  iiaem_matcher uut (
    .MCLK_IN(mclk),
    .RST_B_IN(rst_b),
    .HSEL_IN(hsel),
    .HADDR_IN(haddr),
    .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize),
    .HWDATA_IN(hwdata),
    .HREADY_IN(hreadyout),
    .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hreadyout),
    .HRESP_OUT(hresp),
    .FRAME_IN(frame),
    .RESULT_OUT(result)
  );

  iiaem_parser_model parser (
    .clk_in(mclk),
    .frame_out(frame)
  );

  // ==========================================================
  // tasks
  // ==========================================================
  task automatic report_and_stop;
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // single whole-word transfer; waits on hready, no fixed latency assumed
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : bus

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, ofs, d, dummy);
  endtask : wr

  task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0, rd);
    chk(rd, exp);
  endtask : rdchk

  task automatic cfg(input logic [2:0] nh, input logic src, input logic [1:0] hop, input logic ty, input logic co);
    wr(OFS_CTRL, {24'h0, co, ty, hop, src, nh});
  endtask : cfg

  // result pulse lands one edge after the valid cycle
  task automatic frm(input logic v6, input logic [7:0] nh, input logic [31:0] src, input logic [7:0] hop,
                     input logic [15:0] tc, input logic exp);
    parser.send(v6, nh, src, hop, tc[7:0], tc[15:8]);
    #1;
    chk({30'h0, result.valid, result.hit}, {30'h0, 1'b1, exp});
  endtask : frm

  // ==========================================================
  // clock and watchdog
  // ==========================================================
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    #(40 * 20000);
    n_fail++;
    report_and_stop();
  end

  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    n_fail = 0;
    checks = 0;
    ofs_tab = '{OFS_CTRL, OFS_NH_VALUE, OFS_SRC_ADDR, OFS_SRC_MASK, OFS_ICMP, OFS_STATUS, 8'h18};
    rst_tab = '{32'h0, 32'h0, 32'h0, SRC_MASK_RST, 32'h0, 32'h0, 32'h0};
    pr = '{PROTO_ICMP6, PROTO_UDP, PROTO_TCP};
    nv = '{8'h00, 8'hff};
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    // reset values, unmapped offset ignores writes
    wr(8'h18, 32'hffffffff);
    for (int i = 0; i < 7; i++) begin
      rdchk(ofs_tab[i], rst_tab[i]);
    end
    // everything don't-care after reset
    frm(1'b1, 8'h11, 32'h12345678, 8'h00, 16'hffff, 1'b1);
    frm(1'b1, 8'h3a, 32'hdeadbeef, 8'hff, 16'h1234, 1'b1);
    frm(1'b0, 8'h3a, 32'h0, 8'h01, 16'h0, 1'b0);
    // specific next header at both range ends
    cfg(3'(NH_SPECIFIC), 1'b0, 2'(HOP_ANY), 1'b0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_NH_VALUE, {24'h0, nv[i]});
      frm(1'b1, nv[i], 32'h0, 8'h01, 16'h0, 1'b1);
      frm(1'b1, nv[i] ^ 8'h01, 32'h0, 8'h01, 16'h0, 1'b0);
    end
    // protocol shortcuts hit only their own protocol
    for (int i = 0; i < 3; i++) begin
      cfg(3'(i + 2), 1'b0, 2'(HOP_ANY), 1'b0, 1'b0);
      for (int j = 0; j < 3; j++) begin
        frm(1'b1, pr[j], 32'h0, 8'h01, 16'h0, i == j);
      end
    end
    // icmp type and code
    wr(OFS_ICMP, 32'h00000480);
    cfg(3'(NH_ICMP), 1'b0, 2'(HOP_ANY), 1'b1, 1'b1);
    frm(1'b1, PROTO_ICMP6, 32'h0, 8'h01, 16'h0480, 1'b1);
    frm(1'b1, PROTO_ICMP6, 32'h0, 8'h01, 16'h0481, 1'b0);
    frm(1'b1, PROTO_ICMP6, 32'h0, 8'h01, 16'h0580, 1'b0);
    cfg(3'(NH_ICMP), 1'b0, 2'(HOP_ANY), 1'b1, 1'b0);
    frm(1'b1, PROTO_ICMP6, 32'h0, 8'h01, 16'h0780, 1'b1);
    cfg(3'(NH_ICMP), 1'b0, 2'(HOP_ANY), 1'b0, 1'b1);
    frm(1'b1, PROTO_ICMP6, 32'h0, 8'h01, 16'h0499, 1'b1);
    frm(1'b1, PROTO_ICMP6, 32'h0, 8'h01, 16'h0399, 1'b0);
    cfg(3'(NH_UDP), 1'b0, 2'(HOP_ANY), 1'b1, 1'b1);
    frm(1'b1, PROTO_UDP, 32'h0, 8'h01, 16'h0000, 1'b1);
    // source low bits under mask; address bit 0 sits under a cleared mask bit
    wr(OFS_SRC_ADDR, 32'h20010003);
    wr(OFS_SRC_MASK, 32'hfffffffe);
    cfg(3'(NH_ANY), 1'b1, 2'(HOP_ANY), 1'b0, 1'b0);
    frm(1'b1, 8'h11, 32'h20010002, 8'h01, 16'h0, 1'b1);
    frm(1'b1, 8'h11, 32'h20010003, 8'h01, 16'h0, 1'b1);
    frm(1'b1, 8'h11, 32'h20010001, 8'h01, 16'h0, 1'b0);
    frm(1'b1, 8'h11, 32'ha0010003, 8'h01, 16'h0, 1'b0);
    wr(OFS_SRC_MASK, 32'h0);
    frm(1'b1, 8'h11, 32'h5a5a5a5a, 8'h01, 16'h0, 1'b1);
    // hop limit
    cfg(3'(NH_ANY), 1'b0, 2'(HOP_ZERO), 1'b0, 1'b0);
    frm(1'b1, 8'h11, 32'h0, 8'h00, 16'h0, 1'b1);
    frm(1'b1, 8'h11, 32'h0, 8'h01, 16'h0, 1'b0);
    frm(1'b1, 8'h11, 32'h0, 8'hff, 16'h0, 1'b0);
    cfg(3'(NH_ANY), 1'b0, 2'(HOP_NONZERO), 1'b0, 1'b0);
    frm(1'b1, 8'h11, 32'h0, 8'h01, 16'h0, 1'b1);
    frm(1'b1, 8'h11, 32'h0, 8'hff, 16'h0, 1'b1);
    cfg(3'(NH_ANY), 1'b0, 2'(HOP_ANY), 1'b0, 1'b0);
    frm(1'b1, 8'h11, 32'h0, 8'h00, 16'h0, 1'b1);
    // hit counter clears on write, then counts two hits
    wr(OFS_STATUS, 32'h0);
    frm(1'b1, 8'h06, 32'h0, 8'h01, 16'h0, 1'b1);
    frm(1'b1, 8'h06, 32'h0, 8'h02, 16'h0, 1'b1);
    // the result pulses have dropped by the read's address edge, so only the count stands
    rdchk(OFS_STATUS, 32'h00020000);
    report_and_stop();
  end

endmodule : iiaem_matcher_tb

//--- verif/iiaem_parser_model.sv
// behavioural model of the frame header parser that feeds the matcher
`timescale 1ns/1ps

// ==========================================================
// parser model
// ==========================================================
module iiaem_parser_model (
  input wire logic clk_in,
  output iiaem_pkg::iiaem_frame_t frame_out
);
  import iiaem_pkg::*;

  initial begin
    frame_out = '0;
  end

  // fields scrambled outside the valid cycle, so late sampling sees garbage
  task automatic send(input logic v6, input logic [7:0] nh, input logic [31:0] src, input logic [7:0] hop,
                      input logic [7:0] ty, input logic [7:0] co);
    iiaem_frame_t f;
    iiaem_frame_t idle;
    f = {1'b1, v6, nh, src, hop, ty, co};
    idle = ~f;
    idle.valid = 1'b0;
    @(posedge clk_in);
    frame_out <= f;
    @(posedge clk_in);
    frame_out <= idle;
  endtask : send

endmodule : iiaem_parser_model
